/* rtl/pwmdb_top.sv */
// PWM generator with dead-band, output control, fault shutdown and an APB register file.
// Assumes APB3 master on pclk; fault_in synchronous to pclk.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - One generator plus output control; generator reaches pins only via output control.
// - A 16-bit counter counts down only or up then down.
// - Two comparators each compare their own value with the running count.
// - Two outputs may be shaped independently from counter and comparator events.
// - Alternatively one complementary pair with dead-band so both are never active.
// - Output control applies normal or inverted polarity per signal.
// - Output control enables or withholds each signal at its pin.
// - A fault input shuts the outputs down without software help.
// - Counter and comparator events raise an interrupt to the processor.
// - 16-bit load value sets period; updates may wait for counter zero.
// - Counter emits zero and load-value events for waveform construction.
// - Each comparator emits a match event; updates may wait for counter zero.
// - Dead-band stage can be bypassed, passing both signals unchanged.
module pwmdb_top #(
  parameter int unsigned CW = 16,
  parameter int unsigned DW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fault_in,
  output logic pwm_a,
  output logic pwm_b,
  output logic irq
);
  localparam int EN = pwmdb_pkg::EVT_N;

  // Register state
  logic [pwmdb_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [CW-1:0] load_sh_q, load_sh_d, load_act_q, load_act_d;
  logic [CW-1:0] cmpa_sh_q, cmpa_sh_d, cmpa_act_q, cmpa_act_d;
  logic [CW-1:0] cmpb_sh_q, cmpb_sh_d, cmpb_act_q, cmpb_act_d;
  logic [2*EN-1:0] gena_q, gena_d, genb_q, genb_d;
  logic [DW-1:0] dbr_q, dbr_d, dbf_q, dbf_d;
  logic [pwmdb_pkg::OUT_W-1:0] outc_q, outc_d;
  logic [EN-1:0] inten_q, inten_d, stat_q, stat_d;
  // Bus answer state
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  // Generator and output state
  logic sig_a_q, sig_a_d, sig_b_q, sig_b_d;
  logic pwm_a_q, pwm_a_d, pwm_b_q, pwm_b_d, irq_q, irq_d;
  logic flt_q, flt_d;
  // Datapath wires
  logic [CW-1:0] cnt;
  logic cnt_up, at_zero, at_load, run, boundary;
  logic [EN-1:0] evt;
  logic db_hi, db_lo, pre_a, pre_b;
  logic wr_en, rd_phase;
  logic [31:0] rsel;
  logic rhit;

  // Applies the actions of every event in priority order; last event wins
  function automatic logic gen_apply(input logic cur, input logic [2*EN-1:0] acts,
                                     input logic [EN-1:0] ev);
    logic v;
    v = cur;
    for (int i = 0; i < EN; i++) begin
      if (ev[i]) begin
        unique case (acts[2*i +: 2])
          pwmdb_pkg::ACT_NONE: v = v;
          pwmdb_pkg::ACT_TOGGLE: v = ~v;
          pwmdb_pkg::ACT_LOW: v = 1'b0;
          pwmdb_pkg::ACT_HIGH: v = 1'b1;
        endcase
      end
    end
    return v;
  endfunction

  assign run = ctrl_q[pwmdb_pkg::CTRL_RUN];

  pwmdb_counter #(.CW(CW)) u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .updown(ctrl_q[pwmdb_pkg::CTRL_UPDOWN]),
    .load_val(load_act_q),
    .cnt(cnt),
    .count_up(cnt_up),
    .at_zero(at_zero),
    .at_load(at_load)
  );

  // Counter and comparator events, only while running
  always_comb begin
    evt = '0;
    if (run) begin
      evt[pwmdb_pkg::EVT_ZERO] = at_zero;
      evt[pwmdb_pkg::EVT_LOAD] = at_load;
      evt[pwmdb_pkg::EVT_CA_UP] = (cnt == cmpa_act_q) && cnt_up;
      evt[pwmdb_pkg::EVT_CA_DN] = (cnt == cmpa_act_q) && !cnt_up;
      evt[pwmdb_pkg::EVT_CB_UP] = (cnt == cmpb_act_q) && cnt_up;
      evt[pwmdb_pkg::EVT_CB_DN] = (cnt == cmpb_act_q) && !cnt_up;
    end
  end
  // Synchronised updates land when the counter is at zero, or at once while stopped
  assign boundary = !run || at_zero;

  // APB phases: one wait state, so pready and prdata come from flops
  assign rd_phase = psel && penable && !pready_q;
  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;

  // Read mux and address decode
  always_comb begin
    rsel = 32'h0000_0000;
    rhit = 1'b1;
    unique case (paddr)
      pwmdb_pkg::OFS_CTRL: rsel[pwmdb_pkg::CTRL_W-1:0] = ctrl_q;
      pwmdb_pkg::OFS_LOAD: rsel[CW-1:0] = load_sh_q;
      pwmdb_pkg::OFS_COUNT: rsel[CW-1:0] = cnt;
      pwmdb_pkg::OFS_CMPA: rsel[CW-1:0] = cmpa_sh_q;
      pwmdb_pkg::OFS_CMPB: rsel[CW-1:0] = cmpb_sh_q;
      pwmdb_pkg::OFS_GENA: rsel[2*EN-1:0] = gena_q;
      pwmdb_pkg::OFS_GENB: rsel[2*EN-1:0] = genb_q;
      pwmdb_pkg::OFS_DBRISE: rsel[DW-1:0] = dbr_q;
      pwmdb_pkg::OFS_DBFALL: rsel[DW-1:0] = dbf_q;
      pwmdb_pkg::OFS_OUTCTL: rsel[pwmdb_pkg::OUT_W-1:0] = outc_q;
      pwmdb_pkg::OFS_INTEN: rsel[EN-1:0] = inten_q;
      pwmdb_pkg::OFS_INTSTAT: rsel[EN-1:0] = stat_q;
      pwmdb_pkg::OFS_STATUS: rsel[0] = flt_q;
      default: rhit = 1'b0;
    endcase
  end

  // Bus answer next state
  always_comb begin
    pready_d = rd_phase;
    pslverr_d = rd_phase && !rhit;
    prdata_d = prdata_q;
    if (rd_phase) begin
      prdata_d = (pwrite || !rhit) ? 32'h0000_0000 : rsel;
    end
  end

  // Register writes and shadow-to-active transfers
  always_comb begin
    ctrl_d = ctrl_q;
    load_sh_d = load_sh_q;
    cmpa_sh_d = cmpa_sh_q;
    cmpb_sh_d = cmpb_sh_q;
    gena_d = gena_q;
    genb_d = genb_q;
    dbr_d = dbr_q;
    dbf_d = dbf_q;
    outc_d = outc_q;
    inten_d = inten_q;
    stat_d = stat_q;
    if (wr_en) begin
      unique case (paddr)
        pwmdb_pkg::OFS_CTRL: ctrl_d = pwdata[pwmdb_pkg::CTRL_W-1:0];
        pwmdb_pkg::OFS_LOAD: load_sh_d = pwdata[CW-1:0];
        pwmdb_pkg::OFS_CMPA: cmpa_sh_d = pwdata[CW-1:0];
        pwmdb_pkg::OFS_CMPB: cmpb_sh_d = pwdata[CW-1:0];
        pwmdb_pkg::OFS_GENA: gena_d = pwdata[2*EN-1:0];
        pwmdb_pkg::OFS_GENB: genb_d = pwdata[2*EN-1:0];
        pwmdb_pkg::OFS_DBRISE: dbr_d = pwdata[DW-1:0];
        pwmdb_pkg::OFS_DBFALL: dbf_d = pwdata[DW-1:0];
        pwmdb_pkg::OFS_OUTCTL: outc_d = pwdata[pwmdb_pkg::OUT_W-1:0];
        pwmdb_pkg::OFS_INTEN: inten_d = pwdata[EN-1:0];
        pwmdb_pkg::OFS_INTSTAT: stat_d = stat_q & ~pwdata[EN-1:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
    // Set beats a clear in the same cycle
    stat_d = stat_d | evt;
    // Active copies follow the shadow at once or only at the boundary
    load_act_d = load_act_q;
    if (!ctrl_q[pwmdb_pkg::CTRL_LOAD_SYNC] || boundary) begin
      load_act_d = load_sh_q;
    end
    cmpa_act_d = cmpa_act_q;
    cmpb_act_d = cmpb_act_q;
    if (!ctrl_q[pwmdb_pkg::CTRL_CMP_SYNC] || boundary) begin
      cmpa_act_d = cmpa_sh_q;
      cmpb_act_d = cmpb_sh_q;
    end
  end

  // Waveform construction; a stopped generator rests low
  always_comb begin
    sig_a_d = run ? gen_apply(sig_a_q, gena_q, evt) : 1'b0;
    sig_b_d = run ? gen_apply(sig_b_q, genb_q, evt) : 1'b0;
  end

  // Pair derives from signal A alone; signal B is dropped in pair mode
  pwmdb_deadband #(.DW(DW)) u_deadband (
    .pclk(pclk),
    .presetn(presetn),
    .in_sig(sig_a_q),
    .rise_dly(dbr_q),
    .fall_dly(dbf_q),
    .out_hi(db_hi),
    .out_lo(db_lo)
  );

  // Dead-band or bypass, then output control straight into the pin flops
  always_comb begin
    pre_a = ctrl_q[pwmdb_pkg::CTRL_DB_EN] ? db_hi : sig_a_q;
    pre_b = ctrl_q[pwmdb_pkg::CTRL_DB_EN] ? db_lo : sig_b_q;
    flt_d = fault_in;
    // Fault acts on the raw input, so shutdown costs one edge only
    if (fault_in && outc_q[pwmdb_pkg::OUT_FLT_A]) begin
      pwm_a_d = 1'b0;
    end else begin
      pwm_a_d = outc_q[pwmdb_pkg::OUT_EN_A] && (pre_a ^ outc_q[pwmdb_pkg::OUT_INV_A]);
    end
    if (fault_in && outc_q[pwmdb_pkg::OUT_FLT_B]) begin
      pwm_b_d = 1'b0;
    end else begin
      pwm_b_d = outc_q[pwmdb_pkg::OUT_EN_B] && (pre_b ^ outc_q[pwmdb_pkg::OUT_INV_B]);
    end
    irq_d = |(stat_d & inten_d);
  end

  // Register file state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= pwmdb_pkg::RST_CTRL;
      load_sh_q <= pwmdb_pkg::RST_LOAD;
      load_act_q <= pwmdb_pkg::RST_LOAD;
      cmpa_sh_q <= pwmdb_pkg::RST_CMP;
      cmpa_act_q <= pwmdb_pkg::RST_CMP;
      cmpb_sh_q <= pwmdb_pkg::RST_CMP;
      cmpb_act_q <= pwmdb_pkg::RST_CMP;
      gena_q <= pwmdb_pkg::RST_GEN;
      genb_q <= pwmdb_pkg::RST_GEN;
      dbr_q <= '0;
      dbf_q <= '0;
      outc_q <= pwmdb_pkg::RST_OUTCTL;
      inten_q <= pwmdb_pkg::RST_EVT;
      stat_q <= pwmdb_pkg::RST_EVT;
    end else begin
      ctrl_q <= ctrl_d;
      load_sh_q <= load_sh_d;
      load_act_q <= load_act_d;
      cmpa_sh_q <= cmpa_sh_d;
      cmpa_act_q <= cmpa_act_d;
      cmpb_sh_q <= cmpb_sh_d;
      cmpb_act_q <= cmpb_act_d;
      gena_q <= gena_d;
      genb_q <= genb_d;
      dbr_q <= dbr_d;
      dbf_q <= dbf_d;
      outc_q <= outc_d;
      inten_q <= inten_d;
      stat_q <= stat_d;
    end
  end

  // Bus answer registers; the answer always comes one wait state late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // Generated waveform registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_a_q <= 1'b0;
      sig_b_q <= 1'b0;
    end else begin
      sig_a_q <= sig_a_d;
      sig_b_q <= sig_b_d;
    end
  end

  // Pin registers; every pin leaves straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_a_q <= 1'b0;
      pwm_b_q <= 1'b0;
      irq_q <= 1'b0;
      flt_q <= 1'b0;
    end else begin
      pwm_a_q <= pwm_a_d;
      pwm_b_q <= pwm_b_d;
      irq_q <= irq_d;
      flt_q <= flt_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pwm_a = pwm_a_q;
  assign pwm_b = pwm_b_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

/* include/pwmdb_pkg.sv */
// Package for the PWM generator with dead-band: register map, fields, reset values.
// Assumes a 32-bit APB slave decoding the low address byte.
package pwmdb_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LOAD = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMPA = 8'h0c;
  localparam logic [7:0] OFS_CMPB = 8'h10;
  localparam logic [7:0] OFS_GENA = 8'h14;
  localparam logic [7:0] OFS_GENB = 8'h18;
  localparam logic [7:0] OFS_DBRISE = 8'h1c;
  localparam logic [7:0] OFS_DBFALL = 8'h20;
  localparam logic [7:0] OFS_OUTCTL = 8'h24;
  localparam logic [7:0] OFS_INTEN = 8'h28;
  localparam logic [7:0] OFS_INTSTAT = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  // Control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_UPDOWN = 1;
  localparam int CTRL_LOAD_SYNC = 2;
  localparam int CTRL_CMP_SYNC = 3;
  localparam int CTRL_DB_EN = 4;
  localparam int CTRL_W = 5;
  // Output control fields
  localparam int OUT_EN_A = 0;
  localparam int OUT_EN_B = 1;
  localparam int OUT_INV_A = 2;
  localparam int OUT_INV_B = 3;
  localparam int OUT_FLT_A = 4;
  localparam int OUT_FLT_B = 5;
  localparam int OUT_W = 6;
  // Event bit positions, lowest priority first
  localparam int EVT_ZERO = 0;
  localparam int EVT_LOAD = 1;
  localparam int EVT_CA_UP = 2;
  localparam int EVT_CA_DN = 3;
  localparam int EVT_CB_UP = 4;
  localparam int EVT_CB_DN = 5;
  localparam int EVT_N = 6;
  // Generator action codes, two bits per event
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;
  // Reset values
  localparam logic [CTRL_W-1:0] RST_CTRL = 5'h00;
  localparam logic [15:0] RST_LOAD = 16'hffff;
  localparam logic [15:0] RST_CMP = 16'h0000;
  localparam logic [2*EVT_N-1:0] RST_GEN = 12'h000;
  localparam logic [OUT_W-1:0] RST_OUTCTL = 6'h00;
  localparam logic [EVT_N-1:0] RST_EVT = 6'h00;
endpackage

/* rtl/pwmdb_counter.sv */
// Period counter of the PWM generator: down-only or up/down, with zero and load events.
// Assumes one clock; the load value is the active (already synchronised) copy.
`timescale 1ns/1ps
`default_nettype none
module pwmdb_counter #(
  parameter int unsigned CW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic updown,
  input wire logic [CW-1:0] load_val,
  output logic [CW-1:0] cnt,
  output logic count_up,
  output logic at_zero,
  output logic at_load
);
  localparam logic [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};
  logic [CW-1:0] cnt_q, cnt_d;
  logic up_q, up_d;

  // Next count; a stopped counter parks where its next period starts
  always_comb begin
    cnt_d = cnt_q;
    up_d = up_q;
    if (!run) begin
      cnt_d = updown ? '0 : load_val;
      up_d = updown;
    end else if (!updown) begin
      up_d = 1'b0;
      cnt_d = (cnt_q == '0) ? load_val : cnt_q - ONE;
    end else if (up_q) begin
      // Turn at the load value; >= guards a load value lowered mid-count
      if (cnt_q >= load_val) begin
        up_d = 1'b0;
        cnt_d = (cnt_q == '0) ? '0 : cnt_q - ONE;
      end else begin
        cnt_d = cnt_q + ONE;
      end
    end else begin
      if (cnt_q == '0) begin
        up_d = 1'b1;
        cnt_d = (load_val == '0) ? '0 : ONE;
      end else begin
        cnt_d = cnt_q - ONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      up_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      up_q <= up_d;
    end
  end

  assign cnt = cnt_q;
  assign count_up = up_q;
  // Counter events for waveform construction
  assign at_zero = (cnt_q == '0);
  assign at_load = (cnt_q == load_val);
endmodule
`default_nettype wire

/* rtl/pwmdb_deadband.sv */
// Dead-band stage: turns one generated signal into a non-overlapping complementary pair.
// Assumes delays are static while the input toggles; a change is compared at once against the running count.
`timescale 1ns/1ps
`default_nettype none
module pwmdb_deadband #(
  parameter int unsigned DW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_sig,
  input wire logic [DW-1:0] rise_dly,
  input wire logic [DW-1:0] fall_dly,
  output logic out_hi,
  output logic out_lo
);
  localparam logic [DW-1:0] ONE = {{(DW-1){1'b0}}, 1'b1};
  logic prev_q, prev_d;
  logic [DW-1:0] cnt_q, cnt_d;
  logic hi_q, hi_d;
  logic lo_q, lo_d;
  logic stable;
  logic [DW-1:0] elapsed;

  // The side being left drops at once on any edge, so they never overlap
  always_comb begin
    stable = (in_sig == prev_q);
    // Cycles since the last input edge; the edge cycle itself counts as zero
    elapsed = stable ? cnt_q : '0;
    prev_d = in_sig;
    cnt_d = cnt_q;
    if (!stable) begin
      cnt_d = ONE;
    end else if (cnt_q != '1) begin
      cnt_d = cnt_q + ONE; // Saturates; delays stay within DW bits
    end
    // A zero delay passes the edge with no lost cycle
    hi_d = in_sig && (elapsed >= rise_dly);
    lo_d = !in_sig && (elapsed >= fall_dly);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      cnt_q <= '0;
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end

  assign out_hi = hi_q;
  assign out_lo = lo_q;
endmodule
`default_nettype wire

/* tb/pwmdb_props.sv */
// Checker on the PWM block ports: APB handshake, fault, enables, pair overlap.
// Assumes pwmdb_top; CTRL and OUTCTL are shadowed from completed APB writes.
`timescale 1ns/1ps
`default_nettype none
module pwmdb_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fault_in,
  input wire logic pwm_a,
  input wire logic pwm_b,
  input wire logic irq
);
  logic [5:0] oc_q, oc_d;
  logic [4:0] ct_q, ct_d;
  logic wr, pair;
  // Shadows, so pin checks can follow software settings
  always_comb begin
    wr = psel && penable && pready && pwrite && !pslverr;
    oc_d = (wr && paddr == pwmdb_pkg::OFS_OUTCTL) ? pwdata[5:0] : oc_q;
    ct_d = (wr && paddr == pwmdb_pkg::OFS_CTRL) ? pwdata[4:0] : ct_q;
    pair = ct_q[pwmdb_pkg::CTRL_DB_EN] && oc_q[3:2] == 2'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_q <= 6'h00;
      ct_q <= 5'h00;
    end else begin
      oc_q <= oc_d;
      ct_q <= ct_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy_wait;
    $rose(penable) && psel |-> !pready ##1 pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("no single wait state");
  property p_rdy_one;
    pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
  property p_err_map;
    pready && paddr > pwmdb_pkg::OFS_STATUS |-> pslverr;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped not refused");
  property p_ok_map;
    pready && paddr <= pwmdb_pkg::OFS_STATUS && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_ok_map: assert property (p_ok_map) else $error("mapped refused");
  property p_flt_a;
    fault_in && oc_q[4] ##1 fault_in && oc_q[4] |-> !pwm_a;
  endproperty
  a_flt_a: assert property (p_flt_a) else $error("a live in fault");
  property p_flt_b;
    fault_in && oc_q[5] ##1 fault_in && oc_q[5] |-> !pwm_b;
  endproperty
  a_flt_b: assert property (p_flt_b) else $error("b live in fault");
  property p_dis_a;
    !oc_q[0] ##1 !oc_q[0] |-> !pwm_a;
  endproperty
  a_dis_a: assert property (p_dis_a) else $error("a not withheld");
  property p_dis_b;
    !oc_q[1] ##1 !oc_q[1] |-> !pwm_b;
  endproperty
  a_dis_b: assert property (p_dis_b) else $error("b not withheld");
  // Pipeline needs a few cycles to settle after a mode change
  property p_pair;
    pair [*4] |-> !(pwm_a && pwm_b);
  endproperty
  a_pair: assert property (p_pair) else $error("pair overlaps");
endmodule
bind pwmdb_top pwmdb_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fault_in(fault_in), .pwm_a(pwm_a),
  .pwm_b(pwm_b), .irq(irq));
`default_nettype wire

/* tb/pwmdb_bridge.sv */
// Half-bridge stand-in: trip request to fault line, counts shoot-through cycles.
// Assumes pwm_a drives the high switch and pwm_b the low one.
`timescale 1ns/1ps
`default_nettype none
module pwmdb_bridge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hi_on,
  input wire logic lo_on,
  input wire logic trip,
  output logic fault,
  output int shoot
);
  logic fault_d;
  int shoot_d;
  // Sense is registered, so the fault stays synchronous to pclk
  always_comb begin
    fault_d = trip;
    shoot_d = shoot + int'(hi_on && lo_on);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault <= 1'b0;
      shoot <= 0;
    end else begin
      fault <= fault_d;
      shoot <= shoot_d;
    end
  end
endmodule
`default_nettype wire

/* tb/pwmdb_tb_top.sv */
// Testbench of the PWM block: APB tasks and pulse counting on the pins.
// Assumes pwmdb_top with default widths and the bridge model on the pins.
`timescale 1ns/1ps
`default_nettype none
module pwmdb_tb_top;
  logic pclk, presetn, psel, penable, pwrite, trip, pready, pslverr;
  logic fault_in, pwm_a, pwm_b, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int mismatches, n_checks, ha, hb, ra, s0, shoot;
  pwmdb_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_in(fault_in), .pwm_a(pwm_a), .pwm_b(pwm_b), .irq(irq));
  pwmdb_bridge u_bridge (.pclk(pclk), .presetn(presetn), .hi_on(pwm_a), .lo_on(pwm_b),
    .trip(trip), .fault(fault_in), .shoot(shoot));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts high cycles of both pins and rising edges of pwm_a
  task automatic meas(input int n);
    logic p;
    // Lets a setting written just before reach the pin flops first
    repeat (2) @(posedge pclk);
    ha = 0;
    hb = 0;
    ra = 0;
    p = pwm_a;
    repeat (n) begin
      @(negedge pclk);
      ha += int'(pwm_a);
      hb += int'(pwm_b);
      ra += int'(pwm_a && !p);
      p = pwm_a;
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Whole run is under two thousand cycles
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, trip, paddr, pwdata} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Stopped down count reads as LOAD
    for (int a = 0; a <= 'h30; a += 4) begin
      apb(1'b0, 8'(a), 0);
      chk(rd, (a == 4 || a == 8) ? 32'hffff : 32'h0);
    end
    apb(1'b1, pwmdb_pkg::OFS_COUNT, 32'h1234);
    chk(err, 0);
    apb(1'b0, pwmdb_pkg::OFS_COUNT, 0);
    chk(rd, 32'hffff);
    apb(1'b0, 8'h40, 0);
    chk(err, 1);
    chk(rd, 0);
    $display("test regs done");
    apb(1'b1, pwmdb_pkg::OFS_LOAD, 9);
    apb(1'b1, pwmdb_pkg::OFS_CMPA, 4);
    apb(1'b1, pwmdb_pkg::OFS_CMPB, 2);
    apb(1'b1, pwmdb_pkg::OFS_GENA, 32'h083);
    apb(1'b1, pwmdb_pkg::OFS_GENB, 32'h803);
    apb(1'b1, pwmdb_pkg::OFS_OUTCTL, 3);
    apb(1'b1, pwmdb_pkg::OFS_CTRL, 1);
    apb(1'b0, pwmdb_pkg::OFS_LOAD, 0);
    chk(rd, 9);
    repeat (30) @(posedge pclk);
    meas(100);
    chk(ha, 60);
    chk(ra, 10);
    chk(hb, 80);
    apb(1'b1, pwmdb_pkg::OFS_OUTCTL, 7);
    meas(100);
    chk(ha, 40);
    apb(1'b1, pwmdb_pkg::OFS_OUTCTL, 2);
    meas(100);
    chk(ha, 0);
    chk(hb, 80);
    $display("test down done");
    apb(1'b1, pwmdb_pkg::OFS_GENA, 32'h023);
    apb(1'b1, pwmdb_pkg::OFS_OUTCTL, 3);
    apb(1'b1, pwmdb_pkg::OFS_CTRL, 3);
    repeat (40) @(posedge pclk);
    meas(180);
    chk(ha, 40);
    chk(ra, 10);
    chk(hb, 160);
    $display("test updown done");
    apb(1'b1, pwmdb_pkg::OFS_GENA, 32'h083);
    apb(1'b1, pwmdb_pkg::OFS_DBRISE, 2);
    apb(1'b1, pwmdb_pkg::OFS_DBFALL, 3);
    apb(1'b1, pwmdb_pkg::OFS_CTRL, 32'h11);
    repeat (40) @(posedge pclk);
    s0 = shoot;
    meas(100);
    chk(ha, 40);
    chk(hb, 10);
    chk(shoot - s0, 0);
    $display("test deadband done");
    apb(1'b1, pwmdb_pkg::OFS_OUTCTL, 32'h33);
    trip <= 1'b1;
    repeat (4) @(posedge pclk);
    meas(50);
    chk(ha, 0);
    chk(hb, 0);
    apb(1'b0, pwmdb_pkg::OFS_STATUS, 0);
    chk(rd, 1);
    trip <= 1'b0;
    repeat (4) @(posedge pclk);
    meas(100);
    chk(ha, 40);
    $display("test fault done");
    chk(irq, 0);
    apb(1'b0, pwmdb_pkg::OFS_INTSTAT, 0);
    chk(rd[0], 1);
    apb(1'b1, pwmdb_pkg::OFS_INTEN, 1);
    repeat (3) @(posedge pclk);
    chk(irq, 1);
    apb(1'b1, pwmdb_pkg::OFS_CTRL, 0);
    apb(1'b1, pwmdb_pkg::OFS_INTSTAT, 32'h3f);
    repeat (3) @(posedge pclk);
    chk(irq, 0);
    apb(1'b0, pwmdb_pkg::OFS_INTSTAT, 0);
    chk(rd, 0);
    $display("test irq done");
    // Synchronised updates written while running must land at a zero boundary
    apb(1'b1, pwmdb_pkg::OFS_OUTCTL, 3);
    apb(1'b1, pwmdb_pkg::OFS_CTRL, 32'h0d);
    apb(1'b1, pwmdb_pkg::OFS_LOAD, 19);
    apb(1'b1, pwmdb_pkg::OFS_CMPA, 9);
    repeat (60) @(posedge pclk);
    meas(200);
    chk(ha, 110);
    chk(ra, 10);
    chk(hb, 180);
    $display("test sync done");
    give_verdict();
  end
endmodule
`default_nettype wire
